// ---- common/seq_pkg.sv ----
// Notes on behaviour
// - Mode 1: pulses latch run, held bits jog.
// - Mode 1: enabled run key latches running.
// - Mode 1: enabled direction key reverses direction.
// - Held sequencing bits beat keypad actions.
// - Enabled stop key stops unless bits force.
// - Jog accepted only from the ready state.
// - Run request beats a jog request.
// - Mode 2: wire-proof bits, enable gives inhibit.
// - Mode 2: run needs enable, one direction.
// - Modes 2 to 4 ignore keypad keys.
// - Mode 3: run, jog, reverse levels.
// - Mode 4: as mode 2, enable ignored.
// - Mode 4: run needs exactly one direction.
// - Operation needs output enable and no trip.
// - Keypad reference selection overrides sequencing mode.
// - Sequencing bits and enable clear at power-up.
package seq_pkg;
  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // Control register fields
  localparam int CTL_SEQ = 0;
  localparam int CTL_DEN = 4;
  localparam int CTL_KRUN = 5;
  localparam int CTL_KSTOP = 6;
  localparam int CTL_KDIR = 7;
  localparam int CTL_OUTEN = 8;
  localparam int CTL_MODE = 9;
  localparam int CTL_FREF = 12;
  // Output enable set, mode 2, all sequencing bits clear
  localparam logic [31:0] CTRL_RST = 32'h0000_0500;
  localparam logic [31:0] CTRL_MASK = 32'h0000_7FFF;
  // Sequencing modes
  localparam logic [2:0] MODE_LATCH = 3'h1;
  localparam logic [2:0] MODE_WIRE = 3'h2;
  localparam logic [2:0] MODE_PLC = 3'h3;
  localparam logic [2:0] MODE_WPLC = 3'h4;
  localparam logic [2:0] FREF_KEYPAD = 3'h4;
  // Keypad keys
  localparam int N_KEYS = 3;
  localparam int KEY_RUN = 0;
  localparam int KEY_STOP = 1;
  localparam int KEY_DIR = 2;
  // Status register fields
  localparam int STAT_RUN = 0;
  localparam int STAT_JOG = 1;
  localparam int STAT_REV = 2;
  localparam int STAT_INH = 3;
  localparam int STAT_RDY = 4;
  localparam int STAT_TRIP = 5;
  localparam int STAT_LAT = 6;
  // Sequencer states
  typedef enum logic [2:0] {st_inh, st_rdy, st_run, st_jog, st_trip} seq_state_t;
endpackage

// ---- common/key_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// One-cycle key press events
interface key_if;
  logic [seq_pkg::N_KEYS-1:0] press;
  modport src(output press);
  modport dst(input press);
endinterface
`default_nettype wire

// ---- rtl/key_pulse.sv ----
`timescale 1ns/1ps
`default_nettype none
module key_pulse (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [seq_pkg::N_KEYS-1:0] keys_in,
  key_if.src kp
);
  // Synchroniser stages and last level
  logic [seq_pkg::N_KEYS-1:0] meta_r;
  logic [seq_pkg::N_KEYS-1:0] sync_r;
  logic [seq_pkg::N_KEYS-1:0] prev_r;
  logic [seq_pkg::N_KEYS-1:0] press_r;

  // Two stages before any logic reads the keys
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= keys_in;
      sync_r <= meta_r;
    end
  end

  // Rising edge gives one press per push
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev_r <= '0;
      press_r <= '0;
    end
    else
    begin
      prev_r <= sync_r;
      press_r <= sync_r & ~prev_r;
    end
  end

  assign kp.press = press_r;
endmodule
`default_nettype wire

// ---- rtl/drive_run_sequencer.sv ----
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module drive_run_sequencer (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic key_run_in,
  input wire logic key_stop_in,
  input wire logic key_dir_in,
  input wire logic trip_in,
  output logic run_out,
  output logic jog_out,
  output logic reverse_out,
  output logic inhibit_out,
  output logic ready_out
);
  // Reset release synchroniser
  logic rst_meta_r;
  logic rst_n;
  // Register file and bus handshake
  logic [31:0] ctrl_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic wr_go;
  // Control fields
  logic [3:0] seq;
  logic den;
  logic outen;
  logic [2:0] mode;
  logic [2:0] mode_prev_r;
  logic kpad;
  logic mode_chg;
  logic permit;
  logic any_held;
  // Keypad events
  key_if keys ();
  logic k_run;
  logic k_stop;
  logic k_dir;
  // Latched run and direction
  logic run_lat_r;
  logic dir_lat_r;
  // Decoded requests
  logic inh;
  logic run_eff;
  logic jog_lvl;
  logic dir_run;
  logic dir_jog;
  logic wp_mode;
  // Sequencer state
  seq_pkg::seq_state_t state_r;
  seq_pkg::seq_state_t state_nxt;
  logic run_r;
  logic jog_r;
  logic rev_r;
  logic inh_r;
  logic rdy_r;

  // Reset is asserted at once, released after two edges
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Key conditioning
  key_pulse u_keys (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .keys_in({key_dir_in, key_stop_in, key_run_in}),
    .kp(keys.src)
  );

  assign k_run = keys.press[seq_pkg::KEY_RUN];
  assign k_stop = keys.press[seq_pkg::KEY_STOP];
  assign k_dir = keys.press[seq_pkg::KEY_DIR];

  // Field decode
  assign seq = ctrl_r[seq_pkg::CTL_SEQ +: 4];
  assign den = ctrl_r[seq_pkg::CTL_DEN];
  assign outen = ctrl_r[seq_pkg::CTL_OUTEN];
  assign mode = ctrl_r[seq_pkg::CTL_MODE +: 3];
  assign kpad = ctrl_r[seq_pkg::CTL_FREF +: 3] == seq_pkg::FREF_KEYPAD;
  assign mode_chg = (mode != mode_prev_r);
  assign permit = outen && !trip_in;
  assign any_held = |seq;
  assign wp_mode = !kpad && (mode == seq_pkg::MODE_WIRE || mode == seq_pkg::MODE_PLC
                             || mode == seq_pkg::MODE_WPLC);

  // Bus write accepted only at the waitrequest-low edge
  assign wr_go = avs_write_in && !wait_r;

  // One wait cycle per access, then a low cycle
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      wait_r <= 1'b1;
    else if (wait_r && (avs_read_in || avs_write_in))
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  // Control register, byte lanes honoured
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= seq_pkg::CTRL_RST;
    else if (wr_go && avs_address_in == seq_pkg::CTRL_OFS)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (avs_byteenable_in[i])
          ctrl_r[8*i +: 8] <= avs_writedata_in[8*i +: 8] & seq_pkg::CTRL_MASK[8*i +: 8];
      end
    end
  end

  // Read data captured with the ack; unmapped reads give zero
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else if (wait_r && avs_read_in)
    begin
      if (avs_address_in == seq_pkg::CTRL_OFS)
        rdata_r <= ctrl_r;
      else if (avs_address_in == seq_pkg::STAT_OFS)
      begin
        rdata_r <= 32'h0000_0000;
        rdata_r[seq_pkg::STAT_RUN] <= run_r;
        rdata_r[seq_pkg::STAT_JOG] <= jog_r;
        rdata_r[seq_pkg::STAT_REV] <= rev_r;
        rdata_r[seq_pkg::STAT_INH] <= inh_r;
        rdata_r[seq_pkg::STAT_RDY] <= rdy_r;
        rdata_r[seq_pkg::STAT_TRIP] <= trip_in;
        rdata_r[seq_pkg::STAT_LAT] <= run_lat_r;
      end
      else
        rdata_r <= 32'h0000_0000;
    end
  end

  // Mode history for change detection
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      mode_prev_r <= seq_pkg::CTRL_RST[seq_pkg::CTL_MODE +: 3];
    else
      mode_prev_r <= mode;
  end

  // Latched run and direction for mode 1 and keypad control
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_lat_r <= 1'b0;
      dir_lat_r <= 1'b0;
    end
    else if (!permit || mode_chg || wp_mode)
    begin
      // Nothing latched survives a trip, disable, mode change or level mode
      run_lat_r <= 1'b0;
      dir_lat_r <= 1'b0;
    end
    else if (kpad)
    begin
      // Keypad reference: keys work whatever their enables
      if (!den || k_stop)
        run_lat_r <= 1'b0;
      else if (k_run)
        run_lat_r <= 1'b1;
      if (k_dir)
        dir_lat_r <= !dir_lat_r;
    end
    else if (mode == seq_pkg::MODE_LATCH)
    begin
      if (!den)
        run_lat_r <= 1'b0;
      else if (seq[0])
      begin
        // A momentary forward pulse is enough to latch
        run_lat_r <= 1'b1;
        dir_lat_r <= 1'b0;
      end
      else if (seq[2])
      begin
        run_lat_r <= 1'b1;
        dir_lat_r <= 1'b1;
      end
      else if (!any_held)
      begin
        // Keys act only while no bit is forcing; stop beats run
        if (k_stop && ctrl_r[seq_pkg::CTL_KSTOP])
          run_lat_r <= 1'b0;
        else if (k_run && ctrl_r[seq_pkg::CTL_KRUN])
          run_lat_r <= 1'b1;
        if (k_dir && ctrl_r[seq_pkg::CTL_KDIR])
          dir_lat_r <= !dir_lat_r;
      end
    end
  end

  // Request decode per mode; keys play no part in modes 2 to 4
  always_comb
  begin
    inh = 1'b0;
    run_eff = 1'b0;
    jog_lvl = 1'b0;
    dir_run = dir_lat_r;
    dir_jog = dir_lat_r;
    if (kpad)
    begin
      inh = !den;
      run_eff = run_lat_r;
    end
    else
    begin
      case (mode)
        seq_pkg::MODE_LATCH:
        begin
          // Jog only while held; forward wins if both held
          run_eff = run_lat_r;
          jog_lvl = den && (seq[1] || seq[3]);
          dir_jog = !seq[1] && seq[3];
        end
        seq_pkg::MODE_WIRE:
        begin
          // Both direction bits mean stop
          inh = !den;
          run_eff = den && (seq[0] ^ seq[2]) && !seq[1];
          jog_lvl = den && (seq[0] ^ seq[2]) && seq[1];
          dir_run = seq[2];
          dir_jog = seq[2];
        end
        seq_pkg::MODE_PLC:
        begin
          // Enable and bit 3 have no say here
          run_eff = seq[0] && !seq[1];
          jog_lvl = seq[0] && seq[1];
          dir_run = seq[2];
          dir_jog = seq[2];
        end
        seq_pkg::MODE_WPLC:
        begin
          run_eff = (seq[0] ^ seq[2]) && !seq[1];
          jog_lvl = (seq[0] ^ seq[2]) && seq[1];
          dir_run = seq[2];
          dir_jog = seq[2];
        end
        default:
        begin
          // Other selector values give neither run nor jog
          run_eff = 1'b0;
        end
      endcase
    end
  end

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    if (!permit)
      state_nxt = trip_in ? seq_pkg::st_trip : seq_pkg::st_inh;
    else if (inh)
      state_nxt = seq_pkg::st_inh;
    else
    begin
      case (state_r)
        seq_pkg::st_inh, seq_pkg::st_trip:
          state_nxt = seq_pkg::st_rdy;
        seq_pkg::st_rdy:
        begin
          // Run is checked first so it wins over jog
          if (run_eff)
            state_nxt = seq_pkg::st_run;
          else if (jog_lvl)
            state_nxt = seq_pkg::st_jog;
        end
        seq_pkg::st_run:
        begin
          // A jog bit raised while running is still a run
          if (!(run_eff || (wp_mode && jog_lvl)))
            state_nxt = seq_pkg::st_rdy;
        end
        seq_pkg::st_jog:
        begin
          if (run_eff)
            state_nxt = seq_pkg::st_run;
          else if (!jog_lvl)
            state_nxt = seq_pkg::st_rdy;
        end
        default:
          state_nxt = seq_pkg::st_inh;
      endcase
    end
  end

  // State and registered outputs
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= seq_pkg::st_inh;
      run_r <= 1'b0;
      jog_r <= 1'b0;
      rev_r <= 1'b0;
      inh_r <= 1'b1;
      rdy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      run_r <= (state_nxt == seq_pkg::st_run);
      jog_r <= (state_nxt == seq_pkg::st_jog);
      inh_r <= (state_nxt == seq_pkg::st_inh) || (state_nxt == seq_pkg::st_trip);
      rdy_r <= (state_nxt == seq_pkg::st_rdy);
      // Direction only moves while there is motion
      if (state_nxt == seq_pkg::st_jog)
        rev_r <= dir_jog;
      else if (state_nxt == seq_pkg::st_run)
        rev_r <= dir_run;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign run_out = run_r;
  assign jog_out = jog_r;
  assign reverse_out = rev_r;
  assign inhibit_out = inh_r;
  assign ready_out = rdy_r;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  // Jog is entered only from ready
  chk_jog_from_ready: assert property (
    (state_r == seq_pkg::st_jog && $past(state_r) != seq_pkg::st_jog)
      |-> $past(state_r) == seq_pkg::st_rdy)
    else $error("jog entered from a state other than ready");

  // No motion one cycle after permit is lost
  chk_permit_stop: assert property (
    !permit |=> !run_out && !jog_out && inhibit_out)
    else $error("motion without output enable or with trip");

  // Run and jog together give run
  chk_run_over_jog: assert property (
    (state_r == seq_pkg::st_rdy && permit && !inh && run_eff && jog_lvl) |=> run_out)
    else $error("jog chosen over run");

  // Mode 2 runs only with enable and one direction
  chk_wire_run: assert property (
    (run_out && mode == seq_pkg::MODE_WIRE && !kpad && $stable(ctrl_r))
      |-> $past(den && (seq[0] ^ seq[2])))
    else $error("mode 2 ran without enable or one direction");

  // Mode 4 runs only with one direction
  chk_wplc_run: assert property (
    (run_out && mode == seq_pkg::MODE_WPLC && !kpad && $stable(ctrl_r))
      |-> $past(seq[0] ^ seq[2]))
    else $error("mode 4 ran without exactly one direction");

  // Keys leave no latch in modes 2 to 4
  chk_keys_ignored: assert property (
    wp_mode |=> !run_lat_r)
    else $error("latched run in a level mode");

  // Mode 1 enable low drops the latch
  chk_enable_stop: assert property (
    (!kpad && mode == seq_pkg::MODE_LATCH && !den) |=> !run_lat_r)
    else $error("latch kept with drive enable low");

  // Held bits shield the latch from keys
  chk_held_priority: assert property (
    (!kpad && mode == seq_pkg::MODE_LATCH && permit && !mode_chg && den
      && !seq[0] && !seq[2] && (seq[1] || seq[3]))
      |=> $stable(run_lat_r) && $stable(dir_lat_r))
    else $error("key changed latch while a bit was held");

  // Trip or mode change clears the latch
  chk_latch_clear: assert property (
    (trip_in || mode_chg) |=> !run_lat_r)
    else $error("latch survived trip or mode change");

  // Bits and enable start cleared
  chk_power_clear: assert property (
    $rose(rst_n) |-> ctrl_r[4:0] == 5'h00)
    else $error("sequencing bits not clear after reset");
endmodule
`default_nettype wire

// ---- sim/keypad_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Keypad pushbuttons; a released key reads low through its pull-down
module keypad_model (
  input wire logic mclk_in,
  output logic key_run_out,
  output logic key_stop_out,
  output logic key_dir_out
);
  logic [2:0] keys_r; // Held key levels, run/stop/dir
  assign {key_dir_out, key_stop_out, key_run_out} = keys_r;
  initial keys_r = 3'h0;
  // Held long enough for the sync pair, then a gap so the press lands
  task automatic press(input int idx);
    @(posedge mclk_in);
    keys_r[idx] <= 1'b1;
    repeat (4) @(posedge mclk_in);
    keys_r[idx] <= 1'b0;
    repeat (5) @(posedge mclk_in);
  endtask
endmodule
`default_nettype wire

// ---- sim/drive_run_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module drive_run_sequencer_bench;
  localparam logic [3:0] S_RUN = 4'h8; // Order: run, jog, inhibit, ready
  localparam logic [3:0] S_JOG = 4'h4;
  localparam logic [3:0] S_INH = 4'h2;
  localparam logic [3:0] S_RDY = 4'h1;
  logic clk, rst_n, rd, wr, waitreq, trip; // Bus and trip
  logic [3:0] addr, be; // Address and byte lanes
  logic [31:0] wdata, rdata, q;
  logic run, jog, rev, inh, rdy, k_run, k_stop, k_dir; // Drive outputs, keys
  int error_cnt = 0;
  int check_count = 0;
  drive_run_sequencer u_drive_run_sequencer (.mclk_in(clk), .nrst_in(rst_n),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .key_run_in(k_run), .key_stop_in(k_stop),
    .key_dir_in(k_dir), .trip_in(trip), .run_out(run), .jog_out(jog),
    .reverse_out(rev), .inhibit_out(inh), .ready_out(rdy));
  keypad_model u_keypad_model (.mclk_in(clk), .key_run_out(k_run),
    .key_stop_out(k_stop), .key_dir_out(k_dir));
  // Free-running 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Verdict and the single exit point
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One bus transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Bounded wait ran out
    if (waitreq !== 1'b0)
    begin
      error_cnt++;
      $display("ERROR bus waitrequest expected 0 seen %b", waitreq);
      end_sim();
    end
  endtask
  // Control word: mode, sequencing bits, drive enable, key enables, ref, stage
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [3:0] s,
      input logic den, input logic [2:0] ken = 3'h0, input logic [2:0] fr = 3'h0,
      input logic oe = 1'b1);
    return {17'h0, fr, m, oe, ken, den, s};
  endfunction
  // Write control, then give the state machine time to step through
  task automatic wc(input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, 4'h0, d, r);
    repeat (4) @(posedge clk);
  endtask
  task automatic chk_st(input string nm, input logic [3:0] e);
    `CHK(nm, e, {run, jog, inh, rdy})
  endtask
  // Reset values, register readback, unmapped place
  task automatic t_regs();
    bus(1'b0, 4'h0, 32'h0, q);
    `CHK("ctrl reset", 32'h0000_0500, q)
    chk_st("inhibit after reset", S_INH);
    bus(1'b0, 4'h8, 32'h0, q);
    `CHK("unmapped read", 32'h0, q)
    // Lane 0 left out: its ones must not reach the sequencing bits
    be <= 4'hE;
    bus(1'b1, 4'h0, 32'hFFFF_05FF, q);
    be <= 4'hF;
    bus(1'b0, 4'h0, 32'h0, q);
    `CHK("ctrl lanes and upper bits", 32'h0000_0500, q)
    $display("test regs done");
  endtask
  // Level-driven PLC mode, plus trip and stage enable
  task automatic t_mode3();
    wc(ctl(3'h3, 4'h1, 1'b0));
    chk_st("m3 run", S_RUN);
    `CHK("m3 forward", 1'b0, rev)
    bus(1'b0, 4'h4, 32'h0, q);
    `CHK("status run", 1'b1, q[0])
    wc(ctl(3'h3, 4'h5, 1'b0));
    `CHK("m3 reverse", 1'b1, rev)
    wc(ctl(3'h3, 4'h0, 1'b0));
    chk_st("m3 stop", S_RDY);
    wc(ctl(3'h3, 4'h2, 1'b0));
    wc(ctl(3'h3, 4'h3, 1'b0));
    chk_st("m3 jog", S_JOG);
    wc(ctl(3'h3, 4'h0, 1'b0, 3'h7));
    u_keypad_model.press(0);
    chk_st("m3 key ignored", S_RDY);
    wc(ctl(3'h3, 4'h1, 1'b0));
    trip <= 1'b1;
    repeat (4) @(posedge clk);
    chk_st("trip stops", S_INH);
    trip <= 1'b0;
    repeat (4) @(posedge clk);
    chk_st("trip cleared", S_RUN);
    wc(ctl(3'h3, 4'h1, 1'b0, 3'h0, 3'h0, 1'b0));
    chk_st("stage off", S_INH);
    wc(ctl(3'h3, 4'h0, 1'b0));
    $display("test mode3 done");
  endtask
  // Wire-proof modes with and without drive enable
  task automatic t_wire();
    wc(ctl(3'h2, 4'h1, 1'b1));
    chk_st("m2 run", S_RUN);
    wc(ctl(3'h2, 4'h5, 1'b1));
    chk_st("m2 both stop", S_RDY);
    wc(ctl(3'h2, 4'h4, 1'b1));
    `CHK("m2 reverse", 1'b1, rev)
    wc(ctl(3'h2, 4'h4, 1'b0));
    chk_st("m2 inhibit", S_INH);
    wc(ctl(3'h2, 4'h0, 1'b1));
    wc(ctl(3'h2, 4'h2, 1'b1));
    wc(ctl(3'h2, 4'h3, 1'b1));
    chk_st("m2 jog", S_JOG);
    wc(ctl(3'h2, 4'h0, 1'b1, 3'h7));
    u_keypad_model.press(0);
    chk_st("m2 key ignored", S_RDY);
    wc(ctl(3'h4, 4'h4, 1'b0));
    chk_st("m4 run", S_RUN);
    wc(ctl(3'h4, 4'h5, 1'b0));
    chk_st("m4 both stop", S_RDY);
    wc(ctl(3'h4, 4'h2, 1'b0));
    wc(ctl(3'h4, 4'h6, 1'b0));
    chk_st("m4 jog", S_JOG);
    `CHK("m4 jog reverse", 1'b1, rev)
    wc(ctl(3'h4, 4'h0, 1'b0));
    $display("test wire done");
  endtask
  // Latching mode with keypad interplay
  task automatic t_mode1();
    wc(ctl(3'h1, 4'h1, 1'b1, 3'h7));
    wc(ctl(3'h1, 4'h0, 1'b1, 3'h7));
    chk_st("m1 latched", S_RUN);
    wc(ctl(3'h1, 4'h2, 1'b1, 3'h7));
    chk_st("m1 jog refused", S_RUN);
    wc(ctl(3'h1, 4'h0, 1'b1, 3'h7));
    u_keypad_model.press(2);
    `CHK("m1 dir key", 1'b1, rev)
    u_keypad_model.press(1);
    chk_st("m1 stop key", S_RDY);
    u_keypad_model.press(0);
    chk_st("m1 run key", S_RUN);
    wc(ctl(3'h1, 4'h1, 1'b1, 3'h7));
    u_keypad_model.press(2);
    `CHK("m1 held bit wins", 1'b0, rev)
    u_keypad_model.press(1);
    chk_st("m1 stop refused", S_RUN);
    wc(ctl(3'h1, 4'h0, 1'b1, 3'h0));
    u_keypad_model.press(1);
    chk_st("m1 stop disabled", S_RUN);
    trip <= 1'b1;
    repeat (4) @(posedge clk);
    trip <= 1'b0;
    repeat (4) @(posedge clk);
    chk_st("m1 latch cleared", S_RDY);
    // Stage off first, so run and jog meet while the state is ready
    wc(ctl(3'h1, 4'h3, 1'b1, 3'h0, 3'h0, 1'b0));
    wc(ctl(3'h1, 4'h3, 1'b1));
    chk_st("m1 run beats jog", S_RUN);
    wc(ctl(3'h1, 4'h0, 1'b0));
    `CHK("m1 enable stop", 1'b0, run)
    wc(ctl(3'h3, 4'h0, 1'b0));
    wc(ctl(3'h1, 4'h0, 1'b1));
    u_keypad_model.press(0);
    chk_st("m1 run key off", S_RDY);
    wc(ctl(3'h1, 4'h8, 1'b1));
    chk_st("m1 jog rev", S_JOG);
    `CHK("m1 jog rev dir", 1'b1, rev)
    wc(ctl(3'h1, 4'h0, 1'b1));
    $display("test mode1 done");
  endtask
  // Keypad reference takes over from the bits
  task automatic t_keyref();
    wc(ctl(3'h2, 4'h1, 1'b1, 3'h0, 3'h4));
    chk_st("kp bits inert", S_RDY);
    u_keypad_model.press(0);
    chk_st("kp run", S_RUN);
    u_keypad_model.press(1);
    chk_st("kp stop", S_RDY);
    wc(ctl(3'h2, 4'h0, 1'b1));
    $display("test keyref done");
  endtask
  // Main sequence: reset, scenarios, verdict
  initial
  begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    be = 4'hF;
    wdata = 32'h0;
    trip = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_mode3();
    t_wire();
    t_mode1();
    t_keyref();
    end_sim();
  end
endmodule
`default_nettype wire
